// [hdl/sore_top.sv]
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Two digital outputs, indexed one and two
// - General purpose mode drives software level
// - Output-on source shows power output enabled
// - Phase source high for single phase
// - Fault source high while fault present
// - Sequence source high unless sequence stopped
// - Remote source high under remote control
// - Polarity bit inverts the selected level
// - Software reads back actual pin levels
// - Catalog of available sources is readable
// - Remote enable bit writable and readable
// - Auto mode enables at once, warning first
// - Edge mode enables on input rise
// - Edge mode disables on input fall
// - Auto mode defaults to one
// - Remote inhibit bit writable and readable
module sore_top
#(
    parameter int NUM_OUT = 2                         // Number of digital outputs
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               remote_enable_pin,
    input  wire logic               phase_indicator_a,
    input  wire logic               fault_in,
    input  wire logic               sequence_active_in,
    input  wire logic               remote_control_in,
    input  wire logic               indicator_b,
    output logic [NUM_OUT-1:0]      digital_out,
    output logic                    power_out_en,
    output logic                    enable_warning
);

    // The register map holds exactly two configuration words
    if (NUM_OUT != 2)
    begin : g_bad_num
        $error("sore_top supports exactly two digital outputs");
    end

    logic [2:0]          src_r   [NUM_OUT];  // Source selection per pin
    logic [NUM_OUT-1:0]  level_r;            // Fixed level per pin
    logic [NUM_OUT-1:0]  inv_r;              // Polarity per pin
    logic [NUM_OUT-1:0]  dout_r;             // Driven pin levels
    logic                ren_r;              // Remote enable setting
    logic                auto_r;             // Remote enable auto mode
    logic                inh_r;              // Remote inhibit setting
    logic                pwr_r;              // Power output enabled
    logic                warn_r;             // Warning before an auto enable
    logic                boot_r;             // High until the first clock after reset
    logic                pin_prev_r;         // Last synchronised remote input
    logic                cond_prev_r;        // Last auto enable condition
    logic [31:0]         prdata_r;           // Read data
    logic                pready_r;           // Access phase answer
    logic                pslverr_r;          // Unmapped address flag
    logic                pin_lvl;            // Synchronised remote input

    // Remote enable pin crosses in from outside
    sore_sync3 u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in(remote_enable_pin),
        .level_r (pin_lvl)
    );

    // APB decode. Every select is a plain compare of the full byte address,
    // so an offset that is not word aligned falls through to the error answer.
    // Writes act only on the access edge, never in the setup cycle.
    // APB decode
    wire setup_ph  = psel & ~penable;
    wire access_ok = psel & penable & pready_r;
    wire wr_stb    = access_ok & pwrite;
    wire sel_cfg1  = (paddr == sore_pkg::OFS_OUT1_CFG);
    wire sel_cfg2  = (paddr == sore_pkg::OFS_OUT2_CFG);
    wire sel_state = (paddr == sore_pkg::OFS_OUT_STATE);
    wire sel_cat   = (paddr == sore_pkg::OFS_CATALOG);
    wire sel_rem   = (paddr == sore_pkg::OFS_REMOTE);
    wire sel_cmd   = (paddr == sore_pkg::OFS_COMMAND);
    wire sel_pwr   = (paddr == sore_pkg::OFS_POWER);
    wire mapped    = sel_cfg1 | sel_cfg2 | sel_state | sel_cat | sel_rem | sel_cmd | sel_pwr;
    wire wr_rem    = wr_stb & sel_rem;
    wire wr_cmd    = wr_stb & sel_cmd;
    wire sanitize  = wr_cmd & pwdata[sore_pkg::CMD_SANITIZE_BIT];
    wire sw_on     = wr_cmd & pwdata[sore_pkg::CMD_ON_BIT];
    wire sw_off    = wr_cmd & pwdata[sore_pkg::CMD_OFF_BIT];

    // Next remote settings; a sanitize in the same write wins
    wire ren_nxt  = sanitize ? sore_pkg::RST_REN :
                    wr_rem ? pwdata[sore_pkg::REN_BIT] : ren_r;
    wire auto_nxt = sanitize ? sore_pkg::RST_AUTO :
                    wr_rem ? pwdata[sore_pkg::AUTO_BIT] : auto_r;
    wire inh_nxt  = wr_rem ? pwdata[sore_pkg::INH_BIT] : inh_r;

    // Remote enable decisions. Edge mode works only from the synchronised
    // level, so a pulse shorter than about two clocks may be lost; the
    // switch gear is slow, so the short latency is traded for metastability
    // safety. Auto mode reacts to the enable condition becoming true.
    // Remote enable decisions
    wire pin_rise  = pin_lvl & ~pin_prev_r;
    wire pin_fall  = ~pin_lvl & pin_prev_r;
    wire auto_cond = ren_r & auto_r;
    wire auto_req  = auto_cond & (~cond_prev_r | boot_r);
    wire edge_on   = ren_r & ~auto_r & pin_rise;
    wire edge_off  = ren_r & ~auto_r & pin_fall;

    // The word layout matches the write layout, so software can read, modify
    // and write back a configuration without masking.
    // Config word read of one pin
    function automatic logic [31:0] cfg_word(input logic [2:0] s, input logic l, input logic i);
        logic [31:0] w;
        w = 32'h00000000;
        w[sore_pkg::SRC_LSB +: sore_pkg::SRC_W] = s;
        w[sore_pkg::LEVEL_BIT] = l;
        w[sore_pkg::INV_BIT]   = i;
        return w;
    endfunction : cfg_word

    // Read data mux; unmapped and write-only words read as zero.
    // The pin state word reports the registered pin drive, which is exactly
    // what stands on the pins, not the selected level before inversion.
    wire [31:0] rd_mux =
        sel_cfg1  ? cfg_word(src_r[0], level_r[0], inv_r[0]) :
        sel_cfg2  ? cfg_word(src_r[1], level_r[1], inv_r[1]) :
        sel_state ? {30'h0, dout_r} :
        sel_cat   ? sore_pkg::CATALOG_VAL :
        sel_rem   ? {29'h0, inh_r, auto_r, ren_r} :
        sel_pwr   ? {30'h0, warn_r, pwr_r} :
                    32'h00000000;

    // APB answer: ready in the first access cycle, so no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup_ph;
            if (setup_ph)
            begin
                prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_r <= ~mapped;
            end
            else
            begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Each pin drive is registered so the pins never glitch while a status
    // line or the source selection changes; the cost is one clock of delay
    // between a status change and the pin.
    // Per-pin configuration and pin drive
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_pin
        // Pin index one uses the first word, index two the second
        wire wr_cfg = wr_stb & (g == 0 ? sel_cfg1 : sel_cfg2);
        logic sel_lvl;

        // Source selection
        always_comb
        begin
            unique case (src_r[g])
                sore_pkg::SRC_GENERAL:  sel_lvl = level_r[g];
                sore_pkg::SRC_OUTSTATE: sel_lvl = pwr_r;
                sore_pkg::SRC_PHASE:    sel_lvl = phase_indicator_a;
                sore_pkg::SRC_FAULT:    sel_lvl = fault_in;
                sore_pkg::SRC_SEQUENCE: sel_lvl = sequence_active_in;
                sore_pkg::SRC_REMOTE:   sel_lvl = remote_control_in;
                sore_pkg::SRC_INDB:     sel_lvl = indicator_b;
                // Code 7 is not in the catalog and drives low
                default:                sel_lvl = 1'b0;
            endcase
        end

        // Settings and registered pin level
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                src_r[g]   <= sore_pkg::RST_SRC;
                level_r[g] <= sore_pkg::RST_LEVEL;
                inv_r[g]   <= sore_pkg::RST_INV;
                dout_r[g]  <= 1'b0;
            end
            else
            begin
                if (wr_cfg)
                begin
                    src_r[g]   <= pwdata[sore_pkg::SRC_LSB +: sore_pkg::SRC_W];
                    level_r[g] <= pwdata[sore_pkg::LEVEL_BIT];
                    inv_r[g]   <= pwdata[sore_pkg::INV_BIT];
                end
                dout_r[g] <= sel_lvl ^ inv_r[g];
            end
        end
    end

    // Sanitize and a plain register write share one next-value path, so the
    // sanitize can never be lost to a write in the same transfer.
    // Remote settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ren_r  <= sore_pkg::RST_REN;
            auto_r <= sore_pkg::RST_AUTO;
            inh_r  <= sore_pkg::RST_INH;
        end
        else
        begin
            ren_r  <= ren_nxt;
            auto_r <= auto_nxt;
            inh_r  <= inh_nxt;
        end
    end

    // The input history resets to the idle level of the pin, so the release
    // of reset never looks like a rising edge of the remote enable input.
    // Inhibit does not freeze this history.
    // History for edge detection of the input and the auto condition
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_r  <= 1'b0;
            cond_prev_r <= 1'b0;
            boot_r      <= 1'b1;
        end
        else
        begin
            pin_prev_r  <= pin_lvl;
            cond_prev_r <= auto_cond;
            // The boot request is spent on the first cycle after reset
            boot_r      <= 1'b0;
        end
    end

    // Power output control. The warning is raised for one cycle and the
    // output follows in the next; inhibit outranks every enable source.
    // A software on or off request that meets the warning cycle or a fresh
    // auto request is dropped; software must read the power word to confirm.
    // Auto mode never switches the output off by itself, so only a software
    // off request or the inhibit ends an auto enable.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_r  <= 1'b0;
            warn_r <= 1'b0;
        end
        else
        begin
            if (inh_r)
            begin
                pwr_r  <= 1'b0;
                warn_r <= 1'b0;
            end
            else if (warn_r)
            begin
                pwr_r  <= 1'b1;
                warn_r <= 1'b0;
            end
            else if (auto_req)
            begin
                warn_r <= 1'b1;
            end
            else if (edge_on | sw_on)
            begin
                pwr_r <= 1'b1;
            end
            else if (edge_off | sw_off)
            begin
                pwr_r <= 1'b0;
            end
        end
    end

    // Ports straight from flip-flops
    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign digital_out    = dout_r;
    assign power_out_en   = pwr_r;
    assign enable_warning = warn_r;

endmodule : sore_top

// [include/sore_pkg.sv]
// Shared constants of the status output and remote enable block
package sore_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_OUT1_CFG   = 8'h00;  // Pin 1 source, level, polarity
    localparam logic [7:0] OFS_OUT2_CFG   = 8'h04;  // Pin 2 source, level, polarity
    localparam logic [7:0] OFS_OUT_STATE  = 8'h08;  // Pin levels, read only
    localparam logic [7:0] OFS_CATALOG    = 8'h0C;  // Available sources, read only
    localparam logic [7:0] OFS_REMOTE     = 8'h10;  // Remote enable, auto, inhibit
    localparam logic [7:0] OFS_COMMAND    = 8'h14;  // Sanitize and output on/off
    localparam logic [7:0] OFS_POWER      = 8'h18;  // Power output state, read only

    // Output configuration fields
    localparam int SRC_LSB   = 0;                     // Source code, 3 bits
    localparam int SRC_W     = 3;
    localparam int LEVEL_BIT = 4;                     // Fixed level in general purpose mode
    localparam int INV_BIT   = 8;                     // Polarity inversion

    // Remote control fields
    localparam int REN_BIT   = 0;                     // Remote enable
    localparam int AUTO_BIT  = 1;                     // Remote enable auto mode
    localparam int INH_BIT   = 2;                     // Remote inhibit

    // Command fields, write one to act
    localparam int CMD_SANITIZE_BIT = 0;
    localparam int CMD_ON_BIT       = 1;
    localparam int CMD_OFF_BIT      = 2;

    // Source selections of a digital output
    typedef enum logic [2:0] {
        SRC_GENERAL  = 3'h0,                          // Fixed level from software
        SRC_OUTSTATE = 3'h1,                          // Power output enabled
        SRC_PHASE    = 3'h2,                          // Single phase configuration
        SRC_FAULT    = 3'h3,                          // Fault present
        SRC_SEQUENCE = 3'h4,                          // Transient sequence active
        SRC_REMOTE   = 3'h5,                          // Remote control
        SRC_INDB     = 3'h6                           // Auxiliary indicator b
    } sore_src_t;

    // Bit set for each implemented source code
    localparam logic [31:0] CATALOG_VAL = 32'h0000007F;

    // Reset values
    localparam logic [2:0] RST_SRC   = 3'h1;          // Output-on indicator
    localparam logic       RST_LEVEL = 1'b0;
    localparam logic       RST_INV   = 1'b0;
    localparam logic       RST_REN   = 1'b0;
    localparam logic       RST_AUTO  = 1'b1;
    localparam logic       RST_INH   = 1'b0;

endpackage : sore_pkg

// [hdl/sore_sync3.sv]
`timescale 1ns/100ps
// Three stage synchroniser; the level moves once stages two and three agree
module sore_sync3
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level_r
);

    logic s1_r;     // Metastable stage, read only by s2_r
    logic s2_r;     // Second stage
    logic s3_r;     // Third stage

    // Shift chain and agreement filter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Only a settled value is passed on
            if (s2_r == s3_r)
            begin
                level_r <= s3_r;
            end
        end
    end

endmodule : sore_sync3

// [testbench/sore_assertions.sv]
`timescale 1ns/100ps
// Port-level checks of the status output and remote enable block
module sore_assertions
#(
    parameter int NUM_OUT = 2                          // Same pin count as the design
)
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               remote_enable_pin,
    input wire logic               phase_indicator_a,
    input wire logic               fault_in,
    input wire logic               sequence_active_in,
    input wire logic               remote_control_in,
    input wire logic               indicator_b,
    input wire logic [NUM_OUT-1:0] digital_out,
    input wire logic               power_out_en,
    input wire logic               enable_warning
);
    // One domain, so one clock and one reset serve every check
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire logic acc = psel && penable && pready;        // Transfer completes this edge
    wire logic rd_acc = acc && !pwrite;                // Read completes this edge
    wire logic inh_wr = acc && pwrite && paddr == sore_pkg::OFS_REMOTE
                        && pwdata[sore_pkg::INH_BIT];

    property p_answer; psel && !penable |=> pready; endproperty
    property p_rdy_one; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
    property p_catalog;
        rd_acc && paddr == sore_pkg::OFS_CATALOG |-> prdata == sore_pkg::CATALOG_VAL;
    endproperty
    property p_state;
        rd_acc && paddr == sore_pkg::OFS_OUT_STATE && $stable(digital_out)
            |-> prdata[NUM_OUT-1:0] == digital_out;
    endproperty
    property p_warn_pulse; enable_warning |=> !enable_warning; endproperty
    property p_warn_pwr; enable_warning |=> power_out_en; endproperty
    // The setting lands on the write edge and the output drops one edge later
    property p_inhibit; inh_wr |-> ##2 !power_out_en [*4]; endproperty

    a_answer: assert property (p_answer) else $error("no answer after setup");
    a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
    a_err: assert property (p_err) else $error("bad error answer");
    a_catalog: assert property (p_catalog) else $error("catalog value wrong");
    a_state: assert property (p_state) else $error("pin level readback wrong");
    a_warn_pulse: assert property (p_warn_pulse) else $error("warning too long");
    a_warn_pwr: assert property (p_warn_pwr) else $error("no enable after warning");
    a_inhibit: assert property (p_inhibit) else $error("output on while inhibited");

    // Main scenarios reached
    c_warn: cover property (enable_warning);
    c_err: cover property (pslverr);
    c_inh: cover property (inh_wr);
endmodule : sore_assertions

bind sore_top sore_assertions #(.NUM_OUT(NUM_OUT)) sore_assertions_i
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .remote_enable_pin, .phase_indicator_a, .fault_in, .sequence_active_in,
    .remote_control_in, .indicator_b, .digital_out, .power_out_en, .enable_warning
);

// [testbench/sore_ext_model.sv]
`timescale 1ns/100ps
// Outside switch gear driving the remote enable line
module sore_ext_model
(
    input  wire logic level_req,
    output logic      remote_enable_pin
);
    // Edges land off the bench clock grid, as a real switch would
    initial remote_enable_pin = 1'b0;
    always @(level_req)
    begin
        remote_enable_pin <= #230 level_req;
    end
endmodule : sore_ext_model

// [testbench/test_status_output_and_remote_enable.sv]
`timescale 1ns/100ps
// Self-checking bench of the status output and remote enable block
module test_status_output_and_remote_enable;
    logic        pclk, presetn, psel, penable, pwrite;  // Clock, reset, bus strobes
    logic [7:0]  paddr;                                 // Bus address
    logic [31:0] pwdata, prdata, rdat;                  // Bus data
    logic        pready, pslverr, rerr;                 // Bus answer
    logic        pin_req, remote_enable_pin;            // Remote line request and pin
    logic [4:0]  st;                                    // Status lines
    logic [1:0]  digital_out;                           // Output pins
    logic        power_out_en, enable_warning;          // Power control
    int          n_fail, checked;                       // Mismatches, comparisons

    sore_top #(.NUM_OUT(2)) sore_top_i
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .remote_enable_pin, .phase_indicator_a(st[0]), .fault_in(st[1]),
        .sequence_active_in(st[2]), .remote_control_in(st[3]), .indicator_b(st[4]),
        .digital_out, .power_out_en, .enable_warning
    );
    sore_ext_model sore_ext_model_i (.level_req(pin_req), .remote_enable_pin);

    // 10 MHz bus clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Count a comparison, report it if it differs
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
            n_fail++;
        end
    endtask : chk

    // One bus transfer; the answer is taken at the rising edge with pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states are up to the slave; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdat, rerr);
        chk(nm, exp, rdat);
    endtask : rd

    // Wait a bounded time for the power output to reach a level
    task automatic wpow(input logic exp, input int lim);
        int n;
        n = 0;
        while (power_out_en !== exp && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        chk("power", exp, power_out_en);
    endtask : wpow

    task automatic t_reset;
        rd("cfg1", sore_pkg::OFS_OUT1_CFG, 32'h1);
        rd("cfg2", sore_pkg::OFS_OUT2_CFG, 32'h1);
        rd("remote", sore_pkg::OFS_REMOTE, 32'h2);
        rd("catalog", sore_pkg::OFS_CATALOG, sore_pkg::CATALOG_VAL);
        chk("pins", 32'h0, digital_out);
        $display("test reset done");
    endtask : t_reset

    // Every source code, status level and polarity on both pins
    task automatic t_src;
        logic e;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 8; c++)
                for (int k = 0; k < 4; k++)
                begin
                    st <= {5{k[0]}};
                    wr(p ? 8'h04 : 8'h00, {23'h0, k[1], 3'h0, k[0], 1'b0, c[2:0]});
                    e = ((c == 1 || c == 7) ? 1'b0 : k[0]) ^ k[1];
                    apb(1'b0, sore_pkg::OFS_OUT_STATE, 32'h0, rdat, rerr);
                    chk("state", e, rdat[p]);
                    chk("pin", e, digital_out[p]);
                end
        wr(sore_pkg::OFS_OUT1_CFG, 32'h1);
        wr(sore_pkg::OFS_OUT2_CFG, 32'h1);
        $display("test sources done");
    endtask : t_src

    task automatic t_auto;
        wr(sore_pkg::OFS_REMOTE, 32'h3);
        repeat (2) @(negedge pclk);
        chk("warn", 32'h1, enable_warning);
        chk("early", 32'h0, power_out_en);
        @(negedge pclk);
        chk("power", 32'h1, power_out_en);
        @(negedge pclk);
        chk("pins", 32'h3, digital_out);
        rd("remote", sore_pkg::OFS_REMOTE, 32'h3);
        rd("power", sore_pkg::OFS_POWER, 32'h1);
        wr(sore_pkg::OFS_COMMAND, 32'h4);
        wpow(1'b0, 5);
        $display("test auto done");
    endtask : t_auto

    task automatic t_edge;
        wr(sore_pkg::OFS_REMOTE, 32'h1);
        pin_req <= 1'b1;
        wpow(1'b1, 12);
        pin_req <= 1'b0;
        wpow(1'b0, 12);
        $display("test edge done");
    endtask : t_edge

    task automatic t_inh;
        wr(sore_pkg::OFS_COMMAND, 32'h2);
        wpow(1'b1, 5);
        wr(sore_pkg::OFS_REMOTE, 32'h5);
        wpow(1'b0, 5);
        rd("remote", sore_pkg::OFS_REMOTE, 32'h5);
        pin_req <= 1'b1;
        repeat (12) @(negedge pclk);
        chk("power", 32'h0, power_out_en);
        pin_req <= 1'b0;
        repeat (12) @(negedge pclk);
        $display("test inhibit done");
    endtask : t_inh

    // Sanitize, then refused and write-only places
    task automatic t_misc;
        wr(sore_pkg::OFS_REMOTE, 32'h1);
        wr(sore_pkg::OFS_COMMAND, 32'h1);
        rd("remote", sore_pkg::OFS_REMOTE, 32'h2);
        rd("command", sore_pkg::OFS_COMMAND, 32'h0);
        rd("unmapped", 8'h1C, 32'h0);
        chk("slverr", 32'h1, rerr);
        $display("test misc done");
    endtask : t_misc

    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Tests need about 510 cycles; allow more than ten times that
    initial
    begin
        #600000;
        n_fail++;
        summarize();
    end

    initial
    begin
        {n_fail, checked} = {32'sd0, 32'sd0};
        {presetn, psel, penable, pwrite, pin_req, paddr, pwdata, st} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_src();
        t_auto();
        t_edge();
        t_inh();
        t_misc();
        summarize();
    end
endmodule : test_status_output_and_remote_enable
